// ---- rtl/pfd_edge_sync.sv ----
// three-stage synchroniser with rising edge detect for one pin
// assumes the pin is asynchronous to i_clk
`timescale 1ns/1ps

module pfd_edge_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise
);

    // ----------------------------------------
    // synchroniser chain
    // ----------------------------------------
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // level changes only when stages two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_q <= 1'h0;
        end else if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end

    assign o_level = lvl_q;
    // rise seen the cycle the agreed level moves up
    assign o_rise  = (s2_q == s3_q) && s3_q && !lvl_q;

endmodule // pfd_edge_sync

// ---- rtl/pfd_pkg.sv ----
// constants shared by the phase/frequency detector files
// assumes a single 25 MHz system clock domain
package pfd_pkg;

    // ----------------------------------------
    // clock and prescaler
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int PRESCALE_RATIO = 256;
    localparam int PRESCALE_W     = 8;

    // ----------------------------------------
    // charge pump drive states
    // ----------------------------------------
    localparam logic [1:0] PUMP_OFF    = 2'h0;
    localparam logic [1:0] PUMP_SOURCE = 2'h1;
    localparam logic [1:0] PUMP_SINK   = 2'h2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic       FLAG_RST = 1'h0;
    localparam logic [7:0] DIV_RST  = 8'h00;

endpackage : pfd_pkg

// ---- rtl/pfd_top.sv ----
// phase/frequency detector with divide-by-256 prescaler and tri-state pump
// assumes both pins are slow against the 25 MHz clock, so every edge is seen
`timescale 1ns/1ps

module pfd_top #(
    parameter int DIV_RATIO = pfd_pkg::PRESCALE_RATIO
) (
    input  wire logic I_CLK,
    input  wire logic I_RST,
    input  wire logic I_VCO_IN,
    input  wire logic I_REF_OSC_IN,
    output logic      O_REF_OSC_FEEDBACK_OUT,
    output logic      O_DIVIDED_VCO_SIGNAL,
    output logic      O_REFERENCE_SIGNAL,
    output logic      O_PHASE_ERROR_OUT_O,
    output logic      O_PHASE_ERROR_OUT_OE,
    output logic      O_PUMP_SINK,
    output logic      O_PUMP_SOURCE
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    // divider is a power of two that fits the counter
    if (DIV_RATIO < 2 || DIV_RATIO > (1 << pfd_pkg::PRESCALE_W) ||
        (DIV_RATIO & (DIV_RATIO - 1)) != 0) begin : g_bad_div
        $error("DIV_RATIO must be a power of two from 2 to 256");
    end

    // counter width taken once, so the casts below stay short
    localparam int CNT_W = pfd_pkg::PRESCALE_W;

    localparam logic [CNT_W-1:0] DIV_HALF = CNT_W'(DIV_RATIO / 2);
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(DIV_RATIO - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // next prescaler count; wraps to zero after the last vco edge of a cycle
    function automatic logic [CNT_W-1:0] next_count(input logic [CNT_W-1:0] cnt);
        return (cnt == DIV_LAST) ? pfd_pkg::DIV_RST : cnt + CNT_ONE;
    endfunction

    // pump code from the two flags; none or both leaves the pin floating
    function automatic logic [1:0] pump_code(input logic up, input logic dn);
        logic [1:0] code;
        code = pfd_pkg::PUMP_OFF;
        unique case ({up, dn})
            2'h2:    code = pfd_pkg::PUMP_SOURCE;
            2'h1:    code = pfd_pkg::PUMP_SINK;
            default: code = pfd_pkg::PUMP_OFF;
        endcase
        return code;
    endfunction

    // drive decode shared by the pin and the indicator registers
    function automatic logic pump_is(input logic [1:0] code, input logic [1:0] kind);
        return code == kind;
    endfunction

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic vco_rise;
    logic ref_lvl;
    logic ref_rise;

    pfd_edge_sync u_vco_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_pin   (I_VCO_IN),
        .o_level (),
        .o_rise  (vco_rise)
    );

    // reference buffer stage: synchronised copy of the oscillator pin
    pfd_edge_sync u_ref_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_pin   (I_REF_OSC_IN),
        .o_level (ref_lvl),
        .o_rise  (ref_rise)
    );

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic [pfd_pkg::PRESCALE_W-1:0] div_cnt_q;
    logic                           div_out_q;
    logic                           div_rise;

    // counts vco rising edges, output high for the second half of the count
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            div_cnt_q <= pfd_pkg::DIV_RST;
        end else if (vco_rise) begin
            div_cnt_q <= next_count(div_cnt_q);
        end
    end

    // divided output rises once per DIV_RATIO vco edges
    assign div_rise = vco_rise && (div_cnt_q == DIV_HALF - CNT_ONE);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            div_out_q <= pfd_pkg::FLAG_RST;
        end else if (vco_rise) begin
            div_out_q <= (div_cnt_q >= DIV_HALF - CNT_ONE) && (div_cnt_q != DIV_LAST);
        end
    end

    // ----------------------------------------
    // edge flags
    // ----------------------------------------
    logic up_q;   // reference edge seen first
    logic dn_q;   // divided vco edge seen first
    logic up_d;
    logic dn_d;

    // each flag sets on its own edge; both clear once both are set, so a
    // lagging edge ends the pulse in the same cycle it arrives
    always_comb begin
        up_d = up_q || ref_rise;
        dn_d = dn_q || div_rise;
        if (up_d && dn_d) begin
            up_d = 1'h0;
            dn_d = 1'h0;
        end
    end

    // a flag that stays set across several edges of the other input would
    // lose range; clearing on the pair keeps the full +/- 2 pi window
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            up_q <= pfd_pkg::FLAG_RST;
            dn_q <= pfd_pkg::FLAG_RST;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
        end
    end

    // ----------------------------------------
    // charge pump drive
    // ----------------------------------------
    logic [1:0] pump_d;

    // one flag alone drives; none or both leaves the pin floating
    always_comb begin
        pump_d = pump_code(up_d, dn_d);
    end

    // pin drive: enable high while the pump sinks or sources, so the loop
    // filter sees high impedance whenever the flags agree
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PHASE_ERROR_OUT_OE <= 1'h0;
            O_PHASE_ERROR_OUT_O  <= 1'h0;
        end else begin
            O_PHASE_ERROR_OUT_OE <= !pump_is(pump_d, pfd_pkg::PUMP_OFF);
            O_PHASE_ERROR_OUT_O  <= pump_is(pump_d, pfd_pkg::PUMP_SOURCE);
        end
    end

    // indicators follow the next flag state, so width equals edge spacing;
    // widths are whole clocks, any finer phase error is lost
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PUMP_SOURCE <= 1'h0;
            O_PUMP_SINK   <= 1'h0;
        end else begin
            O_PUMP_SOURCE <= pump_is(pump_d, pfd_pkg::PUMP_SOURCE);
            O_PUMP_SINK   <= pump_is(pump_d, pfd_pkg::PUMP_SINK);
        end
    end

    // ----------------------------------------
    // monitor outputs
    // ----------------------------------------
    // feedback pin is the inverted reference, as the oscillator amplifier does
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_REF_OSC_FEEDBACK_OUT <= 1'h1;
        end else begin
            O_REF_OSC_FEEDBACK_OUT <= !ref_lvl;
        end
    end

    // buffered reference exactly as the detector sees it
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_REFERENCE_SIGNAL <= 1'h0;
        end else begin
            O_REFERENCE_SIGNAL <= ref_lvl;
        end
    end

    // divided vco, high for the second half of each count cycle
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_DIVIDED_VCO_SIGNAL <= 1'h0;
        end else begin
            O_DIVIDED_VCO_SIGNAL <= div_out_q;
        end
    end

endmodule // pfd_top

// ---- tb/pfd_loop_filter.sv ----
// loop filter model: integrates charge from the tri-state pump pin
// assumes one charge unit per clock of drive
`timescale 1ns/1ps
module pfd_loop_filter (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_pump,
    input  wire logic          i_pump_oe,
    output logic signed [15:0] o_charge
);
    // ----------------------------------------
    // integrator, high impedance leaves it alone
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_charge <= 16'sh0000;
        end else if (i_pump_oe) begin
            o_charge <= i_pump ? o_charge + 16'sh0001 : o_charge - 16'sh0001;
        end
    end
endmodule // pfd_loop_filter

// ---- tb/pfd_top_chk.sv ----
// checker: pump, reference and prescaler output relations
// assumes pins held at least 4 clocks per level
`timescale 1ns/1ps
module pfd_top_chk #(parameter int DIV_RATIO = 256) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_VCO_IN,
    input wire logic I_REF_OSC_IN,
    input wire logic O_REF_OSC_FEEDBACK_OUT,
    input wire logic O_DIVIDED_VCO_SIGNAL,
    input wire logic O_REFERENCE_SIGNAL,
    input wire logic O_PHASE_ERROR_OUT_O,
    input wire logic O_PHASE_ERROR_OUT_OE,
    input wire logic O_PUMP_SINK,
    input wire logic O_PUMP_SOURCE
);
    // ----------------------------------------
    // output relations
    // ----------------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    a_pump_one_way: assert property (
        !(O_PUMP_SINK && O_PUMP_SOURCE)) else $error("sink and source at once");
    a_drive_when_one: assert property (
        O_PHASE_ERROR_OUT_OE == (O_PUMP_SINK || O_PUMP_SOURCE)) else $error("enable not tied to pump");
    a_drive_level: assert property (
        O_PHASE_ERROR_OUT_OE |-> O_PHASE_ERROR_OUT_O == O_PUMP_SOURCE) else $error("pump level wrong");
    a_feedback_inv: assert property (
        O_REF_OSC_FEEDBACK_OUT == !O_REFERENCE_SIGNAL) else $error("feedback not inverted");
    a_ref_follows: assert property (
        $changed(O_REFERENCE_SIGNAL) |-> O_REFERENCE_SIGNAL == $past(I_REF_OSC_IN, 2)) else $error("ref moved alone");
    a_div_on_rise: assert property (
        $changed(O_DIVIDED_VCO_SIGNAL) |-> $past(I_VCO_IN, 2)) else $error("divider moved without vco rise");
    a_div_half_hold: assert property (
        $rose(O_DIVIDED_VCO_SIGNAL) |=> O_DIVIDED_VCO_SIGNAL [*8]) else $error("divided half too short");
    a_reset_quiet: assert property (disable iff (1'h0)
        I_RST |-> O_REF_OSC_FEEDBACK_OUT && !O_PHASE_ERROR_OUT_OE && !O_DIVIDED_VCO_SIGNAL) else $error("reset state");
endmodule // pfd_top_chk

bind pfd_top pfd_top_chk #(.DIV_RATIO(DIV_RATIO)) u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_VCO_IN(I_VCO_IN),
    .I_REF_OSC_IN(I_REF_OSC_IN), .O_REF_OSC_FEEDBACK_OUT(O_REF_OSC_FEEDBACK_OUT),
    .O_DIVIDED_VCO_SIGNAL(O_DIVIDED_VCO_SIGNAL), .O_REFERENCE_SIGNAL(O_REFERENCE_SIGNAL),
    .O_PHASE_ERROR_OUT_O(O_PHASE_ERROR_OUT_O), .O_PHASE_ERROR_OUT_OE(O_PHASE_ERROR_OUT_OE),
    .O_PUMP_SINK(O_PUMP_SINK), .O_PUMP_SOURCE(O_PUMP_SOURCE));

// ---- tb/test_phase_frequency_detector.sv ----
// testbench: pin edge pairs against integrated pump charge
// assumes DIV_RATIO 4, so divided rises are vco rises 2, 6, 10 ...
`timescale 1ns/1ps
module test_phase_frequency_detector;
    // ----------------------------------------
    // clock, dut and filter
    // ----------------------------------------
    localparam int DIV = 4;
    logic clk = 1'h0, rst = 1'h0, vco = 1'h0, ref_pin = 1'h0;
    logic fb, dv, rs, pe_o, pe_oe, src, snk;
    logic signed [15:0] charge;
    int num_errors = 0, compares = 0, vco_cnt = 0;
    always #20 clk = ~clk;
    pfd_top #(.DIV_RATIO(DIV)) dut (.I_CLK(clk), .I_RST(rst), .I_VCO_IN(vco), .I_REF_OSC_IN(ref_pin),
        .O_REF_OSC_FEEDBACK_OUT(fb), .O_DIVIDED_VCO_SIGNAL(dv), .O_REFERENCE_SIGNAL(rs),
        .O_PHASE_ERROR_OUT_O(pe_o), .O_PHASE_ERROR_OUT_OE(pe_oe), .O_PUMP_SINK(snk), .O_PUMP_SOURCE(src));
    pfd_loop_filter u_filter (.i_clk(clk), .i_rst(rst), .i_pump(pe_o), .i_pump_oe(pe_oe), .o_charge(charge));
    task automatic check(input string name, input logic signed [15:0] exp, input logic signed [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // one undivided vco period of 8 clocks
    task automatic vco_rise();
        for (int t = 0; t < 8; t++) begin
            @(posedge clk);
            vco <= (t < 4);
        end
        vco_cnt++;
    endtask
    // equal synchronisers, so pulse width is the gap between pin rises
    task automatic pair(input int ref_at, input int div_at, input bit dbl, input int exp, input string name);
        logic signed [15:0] start;
        int src_n = 0;
        int snk_n = 0;
        int ref_n = 0;
        while ((vco_cnt + 1) % DIV != DIV / 2) vco_rise();
        start = charge;
        // levels read at an edge are the settled ones of the cycle before
        for (int t = 0; t < 40; t++) begin
            @(posedge clk);
            src_n += int'(src);
            snk_n += int'(snk);
            ref_n += int'(rs);
            ref_pin <= (t >= ref_at && t < ref_at + 4) || (dbl && t >= ref_at + 8 && t < ref_at + 12);
            vco <= (t >= div_at && t < div_at + 4);
        end
        vco_cnt++;
        check(name, 16'(exp), 16'(charge - start));
        check("divided", 16'sh0001, {15'h0000, dv});
        check("source_width", 16'((exp > 0) ? exp : 0), 16'(src_n));
        check("sink_width", 16'((exp < 0) ? -exp : 0), 16'(snk_n));
        check("reference_high", 16'(dbl ? 8 : 4), 16'(ref_n));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        check("feedback", 16'sh0001, {15'h0000, fb});
        check("enable", 16'sh0000, {15'h0000, pe_oe});
        rst <= 1'h0;
    endtask
    task automatic t_ref_leads();
        pair(0, 5, 1'h0, 5, "source");
        pair(2, 3, 1'h0, 1, "source_min");
    endtask
    task automatic t_ref_lags();
        pair(7, 0, 1'h0, -7, "sink");
    endtask
    task automatic t_in_lock();
        pair(5, 5, 1'h0, 0, "lock");
    endtask
    task automatic t_ref_faster();
        pair(0, 14, 1'h1, 14, "fast_ref");
    endtask
    task automatic results();
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 40);
        num_errors++;
        results();
    end
    initial begin
        t_reset();
        t_ref_leads();
        t_ref_lags();
        t_in_lock();
        t_ref_faster();
        results();
    end
endmodule // test_phase_frequency_detector
